// ### verilog/sir_pkg.sv
// ************************************************************
// shared constants for the infrared pulse codec
// ************************************************************
package sir_pkg;

  // ************************************************************
  // register map, byte addresses on the wishbone bus
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // control word
  localparam logic [7:0] ADDR_STATUS = 8'h04; // live state, read only

  // control field positions
  localparam int CTRL_RATE_LSB   = 0;  // rate_select_bit0
  localparam int CTRL_RATE_MSB   = 2;  // rate_select_bit2
  localparam int CTRL_MODE_BIT   = 3;  // pulse_mode_select, 1 = monoshot
  localparam int CTRL_CLKSRC_BIT = 4;  // 1 = external 16x clock
  localparam int CTRL_PDOWN_BIT  = 5;  // power_down_in
  localparam int CTRL_W          = 6;  // implemented control bits
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // status field positions
  localparam int STAT_ENC_BIT = 0;     // encoder busy
  localparam int STAT_DEC_BIT = 1;     // decoder stretching
  localparam int STAT_IR_BIT  = 2;     // infrared output level
  localparam int STAT_RX_BIT  = 3;     // uart receive level

  // ************************************************************
  // crystal divider, stored as last count value (divisor - 1)
  // ************************************************************
  localparam logic [6:0] DIV_LAST_2  = 7'h01;
  localparam logic [6:0] DIV_LAST_4  = 7'h03;
  localparam logic [6:0] DIV_LAST_12 = 7'h0b;
  localparam logic [6:0] DIV_LAST_24 = 7'h17;
  localparam logic [6:0] DIV_LAST_6  = 7'h05;
  localparam logic [6:0] DIV_LAST_48 = 7'h2f;
  localparam logic [6:0] DIV_LAST_96 = 7'h5f;

  // ************************************************************
  // bit timing in 16x ticks
  // ************************************************************
  localparam logic [3:0] PHASE_LAST  = 4'hf; // sixteenth tick of a bit
  localparam logic [3:0] PULSE_START = 4'h7; // ticks before the pulse
  localparam logic [3:0] PULSE_END   = 4'ha; // start plus three ticks
  localparam logic [2:0] MONO_CYCLES = 3'h6; // crystal cycles high

  // ************************************************************
  // state machines
  // ************************************************************
  typedef enum logic {ENC_IDLE, ENC_RUN} sir_enc_state_type;
  typedef enum logic {DEC_IDLE, DEC_STRETCH} sir_dec_state_type;

endpackage : sir_pkg

// ### verilog/sir_pulse_encode_decode.sv
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps

// Overview of operation
// (RULE1) crystal divided by rate-select code
// (RULE2) all bit timing counted in 16x ticks
// (RULE3) one pulse per space bit sent
// (RULE4) wait seven ticks, then three ticks high
// (RULE5) consecutive spaces give pulses one bit apart
// (RULE6) mark bits leave infrared output low
// (RULE7) falling infrared input marks a received pulse
// (RULE8) receive output low sixteen ticks per pulse
// (RULE9) stretched low at least three quarters bit
// (RULE10) monoshot gives six crystal cycles high
// (RULE11) power down stops transmit and receive
// (RULE12) host keeps transmit line high when idle
// (RULE13) mode bit picks 3/16 or monoshot pulse
// (RULE14) clock source select; reset clears machines
module sir_pulse_encode_decode (
  input  wire logic        CLOCK_IN,           // crystal clock
  input  wire logic        RESET_N_IN,         // sync, active low
  input  wire logic        WB_CYC_IN,          // bus cycle
  input  wire logic        WB_STB_IN,          // bus strobe
  input  wire logic        WB_WE_IN,           // write enable
  input  wire logic [7:0]  WB_ADR_IN,          // byte address
  input  wire logic [3:0]  WB_SEL_IN,          // byte lanes
  input  wire logic [31:0] WB_DAT_IN,          // write data
  output logic      [31:0] WB_DAT_OUT,         // read data
  output logic             WB_ACK_OUT,         // acknowledge
  input  wire logic        UART_TXD_IN,        // from uart, pin
  output logic             UART_RXD_OUT,       // to uart
  input  wire logic        INFRARED_PULSE_IN,  // from transceiver
  output logic             INFRARED_PULSE_OUT, // to transceiver
  input  wire logic        EXTERNAL_BAUD_X16_CLOCK_IN // sampled
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [sir_pkg::CTRL_W-1:0] ctrl_reg;      // control word
  logic                       ack_reg;       // bus acknowledge
  logic [31:0]                rdata_reg;     // bus read data
  logic                       bus_req;       // new bus request
  logic [2:0]                 rate_select;   // divider code
  logic                       mode_mono;     // monoshot mode
  logic                       clk_ext;       // external 16x clock
  logic                       power_down;    // traffic blocked
  logic                       txd_s1_reg;    // sync stage one
  logic                       txd_s2_reg;    // sync stage two
  logic                       txd_prev_reg;  // edge history
  logic                       irin_s1_reg;   // sync stage one
  logic                       irin_s2_reg;   // sync stage two
  logic                       irin_prev_reg; // edge history
  logic                       xclk_s1_reg;   // sync stage one
  logic                       xclk_s2_reg;   // sync stage two
  logic                       xclk_prev_reg; // edge history
  logic                       txd_fall;      // space bit begins
  logic                       ir_fall;       // pulse arrived
  logic                       ext_rise;      // external tick
  logic [6:0]                 div_cnt_reg;   // crystal divider
  logic                       div_tick;      // divided tick
  logic                       tick;          // selected 16x tick
  sir_pkg::sir_enc_state_type enc_state_reg; // encoder state
  logic [3:0]                 enc_phase_reg; // tick within bit
  logic                       enc_mod;       // 3/16 modulator
  logic                       mod_prev_reg;  // modulator history
  logic [2:0]                 mono_cnt_reg;  // monoshot counter
  logic                       mono_active;   // monoshot high
  sir_pkg::sir_dec_state_type dec_state_reg; // decoder state
  logic [3:0]                 dec_cnt_reg;   // ticks stretched
  logic                       ir_out_reg;    // output flop
  logic                       rx_out_reg;    // output flop

  // ************************************************************
  // helpers
  // ************************************************************
  // divider last count for a rate code
  function automatic logic [6:0] div_last(input logic [2:0] code);
    case (code)
      3'h0: div_last = sir_pkg::DIV_LAST_2;
      3'h1: div_last = sir_pkg::DIV_LAST_4;
      3'h2: div_last = sir_pkg::DIV_LAST_12;
      3'h3: div_last = sir_pkg::DIV_LAST_24;
      3'h4: div_last = sir_pkg::DIV_LAST_6;
      3'h5: div_last = sir_pkg::DIV_LAST_48;
      3'h6: div_last = sir_pkg::DIV_LAST_96;
      // unlisted code falls back to the fastest rate
      default: div_last = sir_pkg::DIV_LAST_2;
    endcase
  endfunction : div_last

  // ************************************************************
  // wishbone slave
  // ************************************************************
  assign bus_req     = WB_CYC_IN && WB_STB_IN && !ack_reg;
  assign rate_select = ctrl_reg[sir_pkg::CTRL_RATE_MSB:
                                sir_pkg::CTRL_RATE_LSB];
  assign mode_mono   = ctrl_reg[sir_pkg::CTRL_MODE_BIT];
  assign clk_ext     = ctrl_reg[sir_pkg::CTRL_CLKSRC_BIT];
  assign power_down  = ctrl_reg[sir_pkg::CTRL_PDOWN_BIT];

  // ack one cycle after the request, dropped the next
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // control write, low byte lane only
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      ctrl_reg <= sir_pkg::CTRL_RESET;
    end else if (bus_req && WB_WE_IN && WB_SEL_IN[0]) begin
      if (WB_ADR_IN == sir_pkg::ADDR_CTRL) begin
        ctrl_reg <= WB_DAT_IN[sir_pkg::CTRL_W-1:0];
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_IN) begin
      rdata_reg <= 32'h0000_0000;
      if (WB_ADR_IN == sir_pkg::ADDR_CTRL) begin
        rdata_reg[sir_pkg::CTRL_W-1:0] <= ctrl_reg;
      end else if (WB_ADR_IN == sir_pkg::ADDR_STATUS) begin
        rdata_reg[sir_pkg::STAT_ENC_BIT] <=
          (enc_state_reg == sir_pkg::ENC_RUN);
        rdata_reg[sir_pkg::STAT_DEC_BIT] <=
          (dec_state_reg == sir_pkg::DEC_STRETCH);
        rdata_reg[sir_pkg::STAT_IR_BIT] <= ir_out_reg;
        rdata_reg[sir_pkg::STAT_RX_BIT] <= rx_out_reg;
      end
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = rdata_reg;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // pins are asynchronous; edges only seen after stage two
  // reset levels match the idle pins, so no false edge after reset
  // external 16x clock is sampled; keep it well below half crystal rate
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      txd_s1_reg    <= 1'b1;
      txd_s2_reg    <= 1'b1;
      txd_prev_reg  <= 1'b1;
      irin_s1_reg   <= 1'b0;
      irin_s2_reg   <= 1'b0;
      irin_prev_reg <= 1'b0;
      xclk_s1_reg   <= 1'b0;
      xclk_s2_reg   <= 1'b0;
      xclk_prev_reg <= 1'b0;
    end else begin
      txd_s1_reg    <= UART_TXD_IN;
      txd_s2_reg    <= txd_s1_reg;
      txd_prev_reg  <= txd_s2_reg;
      irin_s1_reg   <= INFRARED_PULSE_IN;
      irin_s2_reg   <= irin_s1_reg;
      irin_prev_reg <= irin_s2_reg;
      xclk_s1_reg   <= EXTERNAL_BAUD_X16_CLOCK_IN;
      xclk_s2_reg   <= xclk_s1_reg;
      xclk_prev_reg <= xclk_s2_reg;
    end
  end

  // (RULE7) receive pulse edge
  assign ir_fall  = irin_prev_reg && !irin_s2_reg;
  assign txd_fall = txd_prev_reg && !txd_s2_reg;
  assign ext_rise = !xclk_prev_reg && xclk_s2_reg;

  // ************************************************************
  // 16x tick generation
  // ************************************************************
  // (RULE1) divide crystal by code
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN || div_tick) begin
      div_cnt_reg <= 7'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
    end
  end

  // >= also recovers when the code shrinks mid count
  assign div_tick = (div_cnt_reg >= div_last(rate_select));

  // (RULE14) clock source choice
  // (RULE2) one tick per 16x period
  assign tick = clk_ext ? ext_rise : div_tick;

  // ************************************************************
  // encoder
  // ************************************************************
  // (RULE3) space start launches bit
  // (RULE11) power down parks encoder
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN || power_down) begin
      enc_state_reg <= sir_pkg::ENC_IDLE;
      enc_phase_reg <= 4'h0;
    end else if (txd_fall) begin
      // a new space edge realigns the bit
      enc_state_reg <= sir_pkg::ENC_RUN;
      enc_phase_reg <= 4'h0;
    end else if (tick && enc_state_reg == sir_pkg::ENC_RUN) begin
      if (txd_s2_reg && enc_phase_reg < sir_pkg::PULSE_START) begin
        // (RULE6) mark seen before the pulse window: stop quietly
        enc_state_reg <= sir_pkg::ENC_IDLE;
        enc_phase_reg <= 4'h0;
      end else if (enc_phase_reg == sir_pkg::PHASE_LAST) begin
        // (RULE5) roll over; judged early in the next bit, not at the
        // boundary, where the line and the tick race each other
        enc_phase_reg <= 4'h0;
      end else begin
        enc_phase_reg <= enc_phase_reg + 4'h1;
      end
    end
  end

  // (RULE4) three tick window
  // (RULE6) idle means no pulse
  assign enc_mod = (enc_state_reg == sir_pkg::ENC_RUN) &&
                   (enc_phase_reg >= sir_pkg::PULSE_START) &&
                   (enc_phase_reg < sir_pkg::PULSE_END);

  // ************************************************************
  // monoshot
  // ************************************************************
  // (RULE10) six crystal cycles high
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      mod_prev_reg <= 1'b0;
      mono_cnt_reg <= 3'h0;
    end else begin
      mod_prev_reg <= enc_mod;
      if (enc_mod && !mod_prev_reg) begin
        mono_cnt_reg <= sir_pkg::MONO_CYCLES;
      end else if (mono_cnt_reg != 3'h0) begin
        mono_cnt_reg <= mono_cnt_reg - 3'h1;
      end
    end
  end

  assign mono_active = (mono_cnt_reg != 3'h0);

  // ************************************************************
  // decoder
  // ************************************************************
  // (RULE8) stretch for sixteen ticks
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN || power_down) begin
      dec_state_reg <= sir_pkg::DEC_IDLE;
      dec_cnt_reg   <= 4'h0;
    end else if (ir_fall) begin
      // a fresh pulse restarts the bit
      dec_state_reg <= sir_pkg::DEC_STRETCH;
      dec_cnt_reg   <= 4'h0;
    end else if (tick && dec_state_reg == sir_pkg::DEC_STRETCH) begin
      // (RULE9) full bit exceeds three quarters
      if (dec_cnt_reg == sir_pkg::PHASE_LAST) begin
        dec_state_reg <= sir_pkg::DEC_IDLE;
      end else begin
        dec_cnt_reg <= dec_cnt_reg + 4'h1;
      end
    end
  end

  // ************************************************************
  // output flops
  // ************************************************************
  // (RULE13) pulse shape select
  // (RULE11) outputs quiet in power down
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN || power_down) begin
      ir_out_reg <= 1'b0;
      rx_out_reg <= 1'b1;
    end else begin
      ir_out_reg <= mode_mono ? mono_active : enc_mod;
      rx_out_reg <= (dec_state_reg != sir_pkg::DEC_STRETCH);
    end
  end

  assign INFRARED_PULSE_OUT = ir_out_reg;
  assign UART_RXD_OUT       = rx_out_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  logic [6:0] gap_reg;   // cycles since last divided tick
  logic       gap_ok_reg; // gap measured under a steady code

  // helper: measure divider spacing
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      gap_reg    <= 7'h00;
      gap_ok_reg <= 1'b0;
    end else if (bus_req && WB_WE_IN) begin
      gap_reg    <= 7'h00;
      gap_ok_reg <= 1'b0;
    end else if (div_tick) begin
      gap_reg    <= 7'h00;
      gap_ok_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 7'h01;
    end
  end

  sequence s_mono_high;
    mono_active [*6];
  endsequence

  sequence s_pd_quiet;
    !INFRARED_PULSE_OUT && UART_RXD_OUT;
  endsequence

  a_div_period: assert property ( // (RULE1)
    div_tick && gap_ok_reg |-> gap_reg == div_last(rate_select))
    else $error("divided tick spacing wrong");
  a_tick_source: assert property ( // (RULE14)
    clk_ext && !ext_rise |-> !tick)
    else $error("tick from wrong source");
  a_enc_delay: assert property ( // (RULE4)
    $rose(enc_mod) |-> enc_phase_reg == sir_pkg::PULSE_START &&
    enc_state_reg == sir_pkg::ENC_RUN)
    else $error("pulse started at wrong tick");
  a_pulse_end: assert property ( // (RULE4)
    enc_mod && tick && !txd_fall && !power_down &&
    enc_phase_reg == sir_pkg::PULSE_END - 4'h1 |=> !enc_mod)
    else $error("pulse longer than three ticks");
  a_space_train: assert property ( // (RULE5)
    enc_state_reg == sir_pkg::ENC_RUN && tick && !txd_s2_reg &&
    !txd_fall && !power_down && enc_phase_reg == sir_pkg::PHASE_LAST
    |=> enc_state_reg == sir_pkg::ENC_RUN && enc_phase_reg == 4'h0)
    else $error("space train broken");
  a_mark_quiet: assert property ( // (RULE6)
    enc_state_reg == sir_pkg::ENC_IDLE && !mode_mono
    |=> !INFRARED_PULSE_OUT)
    else $error("pulse during mark");
  a_mono_width: assert property ( // (RULE10)
    $rose(mono_active) |-> s_mono_high ##1 !mono_active)
    else $error("monoshot not six cycles");
  a_power_down: assert property ( // (RULE11)
    power_down |=> s_pd_quiet)
    else $error("traffic during power down");
  a_rx_start: assert property ( // (RULE8)
    ir_fall && !power_down |=> dec_state_reg ==
    sir_pkg::DEC_STRETCH && dec_cnt_reg == 4'h0 ##1 !UART_RXD_OUT)
    else $error("received pulse not stretched");
  a_rx_release: assert property ( // (RULE8)
    dec_state_reg == sir_pkg::DEC_STRETCH && tick && !ir_fall &&
    !power_down && dec_cnt_reg == sir_pkg::PHASE_LAST
    |=> dec_state_reg == sir_pkg::DEC_IDLE ##1 UART_RXD_OUT)
    else $error("stretch not released after a bit");
  a_bus_ack: assert property (
    bus_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("bus ack timing wrong");

endmodule : sir_pulse_encode_decode

// ### test/sir_far_end.sv
`timescale 1ns/1ps

// ************************************************************
// far side: host uart transmit line and infrared transceiver
// ************************************************************
module sir_far_end (
  input  wire logic        clock_in,        // crystal clock
  input  wire logic        send_in,         // start a space run
  input  wire logic [15:0] space_cycles_in, // space length, cycles
  input  wire logic        flash_in,        // start a light flash
  input  wire logic [15:0] flash_cycles_in, // flash length, cycles
  output logic             uart_txd_out,    // to codec transmit input
  output logic             infrared_out     // to codec receive input
);
  logic [15:0] space_left_reg = 16'h0000; // space cycles still due
  logic [15:0] flash_left_reg = 16'h0000; // flash cycles still due

  // uart side counts down one space run per request
  always_ff @(posedge clock_in) begin
    if (send_in) begin
      space_left_reg <= space_cycles_in;
    end else if (space_left_reg != 16'h0000) begin
      space_left_reg <= space_left_reg - 16'h0001;
    end
  end

  assign uart_txd_out = (space_left_reg == 16'h0000);

  // transceiver side: flash length may be short or long
  always_ff @(posedge clock_in) begin
    if (flash_in) begin
      flash_left_reg <= flash_cycles_in;
    end else if (flash_left_reg != 16'h0000) begin
      flash_left_reg <= flash_left_reg - 16'h0001;
    end
  end

  // driven low between flashes, never left floating
  assign infrared_out = (flash_left_reg != 16'h0000);
endmodule : sir_far_end

// ### test/sir_pulse_encode_decode_tb.sv
`timescale 1ns/1ps

// ************************************************************
// bench for the infrared pulse codec
// ************************************************************
module sir_pulse_encode_decode_tb;
  typedef struct {
    logic [5:0] ctrl;  // control word to load
    int         div;   // crystal cycles per tick
    int         width; // expected pulse high cycles
  } sir_row_type;

  logic        clock     = 1'b0;   // crystal clock
  logic        reset_n   = 1'b0;   // active low reset
  logic        cyc       = 1'b0;   // bus cycle
  logic        stb       = 1'b0;   // bus strobe
  logic        we        = 1'b0;   // bus write
  logic [7:0]  adr       = 8'h00;  // bus address
  logic [3:0]  sel       = 4'h0;   // byte lanes
  logic [31:0] dat       = 32'h0;  // write data
  logic [31:0] dat_out;            // read data
  logic        ack;                // bus acknowledge
  logic        txd;                // uart transmit line
  logic        rxd;                // uart receive line
  logic        ir_in;              // transceiver receive line
  logic        ir_out;             // transceiver transmit line
  logic        ext_clk   = 1'b0;   // external 16x clock
  int          ext_cnt   = 0;      // half period counter
  logic        send      = 1'b0;   // space request to far side
  logic [15:0] space_len = 16'h0;  // space length
  logic        flash     = 1'b0;   // flash request to far side
  logic [15:0] flash_len = 16'h0;  // flash length
  logic [31:0] q;                  // last read word
  int failures = 0;
  int checks   = 0;
  int rise1, rise2, width, pulses, rx_low, rx_falls;
  // rate codes, external clock and monoshot; code 7 acts as /2
  sir_row_type rows [10] = '{'{6'h00, 2, 6}, '{6'h01, 4, 12},
    '{6'h02, 12, 36}, '{6'h03, 24, 72}, '{6'h04, 6, 18},
    '{6'h05, 48, 144}, '{6'h06, 96, 288}, '{6'h07, 2, 6},
    '{6'h10, 8, 24}, '{6'h0d, 48, 6}};

  sir_pulse_encode_decode sir_pulse_encode_decode_i (
    .CLOCK_IN(clock), .RESET_N_IN(reset_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(dat), .WB_DAT_OUT(dat_out), .WB_ACK_OUT(ack),
    .UART_TXD_IN(txd), .UART_RXD_OUT(rxd), .INFRARED_PULSE_IN(ir_in),
    .INFRARED_PULSE_OUT(ir_out), .EXTERNAL_BAUD_X16_CLOCK_IN(ext_clk));

  sir_far_end sir_far_end_i (
    .clock_in(clock), .send_in(send), .space_cycles_in(space_len),
    .flash_in(flash), .flash_cycles_in(flash_len),
    .uart_txd_out(txd), .infrared_out(ir_in));

  // ************************************************************
  // clocks
  // ************************************************************
  always #20 clock = ~clock;

  // external clock at one eighth of the crystal, well below half
  always @(posedge clock) begin
    ext_cnt <= (ext_cnt == 3) ? 0 : ext_cnt + 1;
    if (ext_cnt == 3) begin
      ext_clk <= ~ext_clk;
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
          input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // a lost ack would hang every later access
    if (ack !== 1'b1) begin
      failures++;
      print_verdict();
    end
    r = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task send_space(input int c);
    @(posedge clock);
    send      <= 1'b1;
    space_len <= 16'(c);
    @(posedge clock);
    send      <= 1'b0;
  endtask : send_space

  task send_flash(input int c);
    @(posedge clock);
    flash     <= 1'b1;
    flash_len <= 16'(c);
    @(posedge clock);
    flash     <= 1'b0;
  endtask : send_flash

  // watch both output lines for a fixed window, settled values
  task observe(input int n);
    logic ir_p;
    logic rx_p;
    rise1 = -1;
    rise2 = -1;
    width = 0;
    pulses = 0;
    rx_low = 0;
    rx_falls = 0;
    ir_p = 1'b0;
    rx_p = 1'b1;
    for (int t = 0; t < n; t++) begin
      @(negedge clock);
      if (ir_out === 1'b1 && ir_p === 1'b0) begin
        pulses++;
        if (pulses == 1) rise1 = t;
        if (pulses == 2) rise2 = t;
      end
      if (ir_out === 1'b1 && pulses == 1) width++;
      if (rxd === 1'b0) rx_low++;
      if (rxd === 1'b0 && rx_p === 1'b1) rx_falls++;
      ir_p = ir_out;
      rx_p = rxd;
    end
  endtask : observe

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    wb(1'b0, 8'h00, 4'hf, 32'h0, q);
    check("ctrl reset", q, 32'h0);
    wb(1'b0, 8'h04, 4'hf, 32'h0, q);
    check("status idle", q, 32'h8);
    // refused accesses still answered
    wb(1'b0, 8'h08, 4'hf, 32'h0, q);
    check("unmapped read", q, 32'h0);
    wb(1'b1, 8'h04, 4'hf, 32'hffff_ffff, q);
    wb(1'b0, 8'h04, 4'hf, 32'h0, q);
    check("status write", q, 32'h8);
    wb(1'b1, 8'h00, 4'he, 32'h0000_003f, q);
    wb(1'b1, 8'h08, 4'hf, 32'h0000_0015, q);
    wb(1'b1, 8'h00, 4'hf, 32'hffff_ffc2, q);
    wb(1'b0, 8'h00, 4'hf, 32'h0, q);
    check("ctrl bits", q, 32'h2);
    foreach (rows[i]) begin
      wb(1'b1, 8'h00, 4'h1, {26'h0, rows[i].ctrl}, q);
      send_space(16 * rows[i].div);
      observe(24 * rows[i].div + 20);
      check("tx pulses", pulses, 1);
      check("tx width", width, rows[i].width);
      check("tx delay", rise1 >= 6 * rows[i].div &&
            rise1 <= 8 * rows[i].div + 10, 1);
      send_flash(3 * rows[i].div);
      observe(20 * rows[i].div + 20);
      check("rx falls", rx_falls, 1);
      check("rx low", rx_low >= 15 * rows[i].div &&
            rx_low <= 16 * rows[i].div + 2, 1);
      check("rx quarter", rx_low >= 12 * rows[i].div, 1);
    end
    wb(1'b1, 8'h00, 4'h1, 32'h0, q);
    send_space(96);
    observe(150);
    check("train pulses", pulses, 3);
    check("train spacing", rise2 - rise1, 32);
    wb(1'b1, 8'h00, 4'h1, 32'h20, q);
    send_space(32);
    observe(60);
    check("pd tx", pulses, 0);
    send_flash(4);
    observe(60);
    check("pd rx", rx_falls, 0);
    wb(1'b1, 8'h00, 4'h1, 32'h05, q);
    send_flash(4);
    repeat (10) @(negedge clock);
    check("stretch low", rxd, 1'b0);
    wb(1'b0, 8'h04, 4'hf, 32'h0, q);
    check("status stretch", q, 32'h2);
    reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    // first two edges after the second release
    repeat (2) @(negedge clock);
    check("reset rxd", rxd, 1'b1);
    check("reset ir", ir_out, 1'b0);
    wb(1'b0, 8'h00, 4'hf, 32'h0, q);
    check("ctrl cleared", q, 32'h0);
    wb(1'b0, 8'h04, 4'hf, 32'h0, q);
    check("status cleared", q, 32'h8);
    print_verdict();
  end
endmodule : sir_pulse_encode_decode_tb
